// *** hdl/spcsr_top.sv ***
// Function
// - End of a transfer sets the done flag, bit 7; only software clears it.
// - An unmasked, set done flag raises the interrupt request.
// - Data write during a transfer sets collision flag, bit 6, interrupts.
// - Slave select low with master mode on sets fault flag, bit 5.
// - Last bit shifted while receive buffer full sets overrun flag, bit 4.
// - Busy bit 3 is high during master transfers, clears when they end.
// - Selected bit 2 reads the inverted slave select pin.
// - Bit 1 written one enables master mode, zero disables it.
// - With master enable zero the port works as a slave.
// - Bit 0 enables the port; zero disables it and stops all transfers; here zero only blocks flag events, busy and slave mode and is handed to the engine.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none

module spcsr_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [spcsr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [spcsr_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [spcsr_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Slave select pin
    input wire logic slave_select_n,
    // Shift engine
    input wire spcsr_pkg::spcsr_evt_t evt,
    output spcsr_pkg::spcsr_cfg_t cfg,
    // Interrupt
    output logic irq
);

    function automatic logic hit(
        input logic [spcsr_pkg::ADDR_W-1:0] addr,
        input logic [spcsr_pkg::ADDR_W-1:0] offset
    );
        hit = (addr == offset);
    endfunction

    logic slave_select_n_sync;
    logic [spcsr_pkg::FLAG_COUNT-1:0] flag_q;
    logic [spcsr_pkg::FLAG_COUNT-1:0] flag_set;
    logic [spcsr_pkg::FLAG_COUNT-1:0] flag_clr;
    logic [spcsr_pkg::FLAG_COUNT-1:0] mask_reg;
    logic tx_busy_reg;
    logic selected_reg;
    logic accept;
    logic wr_ctrl;
    logic wr_mask;
    logic [7:0] ctrl_view;
    spcsr_pkg::spcsr_cfg_t cfg_next;

    spcsr_sync #(
        .RESET_VAL(spcsr_pkg::SLAVE_SELECT_N_RESET)
    ) u_nss_sync (
        .clk(clk),
        .rst(rst),
        .d(slave_select_n),
        .q(slave_select_n_sync)
    );

    // Bus handshake: one wait cycle, then the access completes
    assign accept = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_ctrl = accept && avs_write && avs_byteenable[0]
        && hit(avs_address, spcsr_pkg::ADDR_CTRL);
    assign wr_mask = accept && avs_write && avs_byteenable[0]
        && hit(avs_address, spcsr_pkg::ADDR_IRQ_MASK);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'h1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    assign ctrl_view = {flag_q, tx_busy_reg, selected_reg,
        cfg.master_enable, cfg.port_enable};

    // Unmapped addresses read zero and ignore writes, yet still complete
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= spcsr_pkg::READ_ZERO;
        end else if (avs_read && avs_waitrequest) begin
            if (hit(avs_address, spcsr_pkg::ADDR_CTRL)) begin
                avs_readdata <= {24'h00_0000, ctrl_view};
            end else if (hit(avs_address, spcsr_pkg::ADDR_IRQ_MASK)) begin
                avs_readdata <= {24'h00_0000, mask_reg, 4'h0};
            end else begin
                avs_readdata <= spcsr_pkg::READ_ZERO;
            end
        end
    end

    // Control bits
    always_comb begin
        cfg_next = cfg;
        if (wr_ctrl) begin
            cfg_next.master_enable =
                avs_writedata[spcsr_pkg::BIT_MASTER_EN];
            cfg_next.port_enable = avs_writedata[spcsr_pkg::BIT_PORT_EN];
        end
        // Slave when the port is enabled and master is not chosen
        cfg_next.slave_mode =
            cfg_next.port_enable && !cfg_next.master_enable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg <= spcsr_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_reg <= avs_writedata[7:spcsr_pkg::FLAG_LSB];
        end
    end

    // Flag events; a disabled port raises none
    always_comb begin
        flag_set[spcsr_pkg::IDX_XFER_DONE] =
            cfg.port_enable && evt.xfer_done;
        flag_set[spcsr_pkg::IDX_WRITE_COLLISION] = cfg.port_enable
            && evt.data_write && evt.xfer_active;
        flag_set[spcsr_pkg::IDX_MODE_FAULT] = cfg.port_enable
            && cfg.master_enable && !slave_select_n_sync;
        flag_set[spcsr_pkg::IDX_RX_OVERRUN] = cfg.port_enable
            && evt.last_bit_shifted && evt.rx_buf_full;
    end

    // Write one to clear
    assign flag_clr = wr_ctrl ? avs_writedata[7:spcsr_pkg::FLAG_LSB]
        : spcsr_pkg::FLAGS_RESET;

    spcsr_flags #(
        .N(spcsr_pkg::FLAG_COUNT)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .set(flag_set),
        .clr(flag_clr),
        .q(flag_q)
    );

    // Live status bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_busy_reg <= 1'h0;
        end else begin
            tx_busy_reg <= cfg.port_enable && cfg.master_enable
                && evt.xfer_active;
        end
    end

    // Reads zero while the pin is high; reset leaves the pin image high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selected_reg <= 1'h0;
        end else begin
            selected_reg <= !slave_select_n_sync;
        end
    end

    // Level request until software clears the flag; one cycle behind it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'h0;
        end else begin
            irq <= |(flag_q & mask_reg);
        end
    end

    property p_done_sets;
        @(posedge clk) disable iff (rst)
        (cfg.port_enable && evt.xfer_done)
            |=> flag_q[spcsr_pkg::IDX_XFER_DONE];
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("done flag not set after transfer end");

    property p_done_sticky;
        @(posedge clk) disable iff (rst)
        (flag_q[spcsr_pkg::IDX_XFER_DONE]
            && !(wr_ctrl && avs_writedata[spcsr_pkg::BIT_XFER_DONE]))
            |=> flag_q[spcsr_pkg::IDX_XFER_DONE];
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("done flag dropped without software clear");

    property p_irq_raise;
        @(posedge clk) disable iff (rst)
        (flag_q[spcsr_pkg::IDX_XFER_DONE]
            && mask_reg[spcsr_pkg::IDX_XFER_DONE]) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("unmasked done flag gave no interrupt");

    property p_irq_cause;
        @(posedge clk) disable iff (rst)
        irq |-> $past(|(flag_q & mask_reg));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without an unmasked flag");

    property p_collision;
        @(posedge clk) disable iff (rst)
        (cfg.port_enable && evt.data_write && evt.xfer_active)
            |=> flag_q[spcsr_pkg::IDX_WRITE_COLLISION];
    endproperty
    a_collision: assert property (p_collision)
        else $error("collision flag not set");

    property p_no_collision_idle;
        @(posedge clk) disable iff (rst)
        ($rose(flag_q[spcsr_pkg::IDX_WRITE_COLLISION]))
            |-> $past(evt.data_write && evt.xfer_active);
    endproperty
    a_no_collision_idle: assert property (p_no_collision_idle)
        else $error("collision flag set without a colliding write");

    property p_mode_fault;
        @(posedge clk) disable iff (rst)
        (cfg.port_enable && cfg.master_enable && !slave_select_n_sync)
            |=> flag_q[spcsr_pkg::IDX_MODE_FAULT];
    endproperty
    a_mode_fault: assert property (p_mode_fault)
        else $error("mode fault flag not set");

    property p_overrun;
        @(posedge clk) disable iff (rst)
        (cfg.port_enable && evt.last_bit_shifted && evt.rx_buf_full)
            |=> flag_q[spcsr_pkg::IDX_RX_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun flag not set");

    property p_busy_track;
        @(posedge clk) disable iff (rst)
        (cfg.port_enable && cfg.master_enable && evt.xfer_active)
            |=> tx_busy_reg;
    endproperty
    a_busy_track: assert property (p_busy_track)
        else $error("busy bit low during master transfer");

    property p_busy_end;
        @(posedge clk) disable iff (rst)
        !evt.xfer_active |=> !tx_busy_reg;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy bit stayed high after transfer end");

    property p_selected_low;
        @(posedge clk) disable iff (rst)
        (!slave_select_n) [*4] |-> selected_reg;
    endproperty
    a_selected_low: assert property (p_selected_low)
        else $error("selected bit clear while pin low");

    property p_selected_high;
        @(posedge clk) disable iff (rst)
        (slave_select_n) [*4] |-> !selected_reg;
    endproperty
    a_selected_high: assert property (p_selected_high)
        else $error("selected bit set while pin high");

    property p_master_write;
        @(posedge clk) disable iff (rst)
        wr_ctrl |=> (cfg.master_enable
            == $past(avs_writedata[spcsr_pkg::BIT_MASTER_EN]));
    endproperty
    a_master_write: assert property (p_master_write)
        else $error("master enable does not follow the write");

    property p_slave_mode;
        @(posedge clk) disable iff (rst)
        cfg.slave_mode == (cfg.port_enable && !cfg.master_enable);
    endproperty
    a_slave_mode: assert property (p_slave_mode)
        else $error("slave mode inconsistent with control bits");

    property p_disabled_quiet;
        @(posedge clk) disable iff (rst)
        (!cfg.port_enable && !wr_ctrl) [*2] |-> !tx_busy_reg;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("busy while port disabled");

    property p_reset_zero;
        @(posedge clk)
        $fell(rst) |-> (ctrl_view == spcsr_pkg::CTRL_RESET
            && mask_reg == spcsr_pkg::MASK_RESET && !irq);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("state not zero after reset");

    property p_bus_answer;
        @(posedge clk) disable iff (rst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered in one wait cycle");

endmodule

`default_nettype wire

// *** hdl/spcsr_pkg.sv ***
`default_nettype none

package spcsr_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Field positions in serial_port_control
    localparam int BIT_XFER_DONE = 7;
    localparam int BIT_WRITE_COLLISION = 6;
    localparam int BIT_MODE_FAULT = 5;
    localparam int BIT_RX_OVERRUN = 4;
    localparam int BIT_TX_BUSY = 3;
    localparam int BIT_SELECTED = 2;
    localparam int BIT_MASTER_EN = 1;
    localparam int BIT_PORT_EN = 0;

    // Sticky flags occupy bits 7..4; index 3 of the flag vector is bit 7
    localparam int FLAG_COUNT = 4;
    localparam int FLAG_LSB = 4;
    localparam int IDX_XFER_DONE = 3;
    localparam int IDX_WRITE_COLLISION = 2;
    localparam int IDX_MODE_FAULT = 1;
    localparam int IDX_RX_OVERRUN = 0;

    // Values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 4'h0;
    localparam logic [FLAG_COUNT-1:0] MASK_RESET = 4'h0;
    localparam logic SLAVE_SELECT_N_RESET = 1'h1;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // Latency of the pin synchroniser in clock cycles
    localparam int SYNC_STAGES = 2;

    // Status and strobes from the shift engine, same clock domain
    typedef struct packed {
        logic xfer_done;
        logic xfer_active;
        logic last_bit_shifted;
        logic data_write;
        logic rx_buf_full;
    } spcsr_evt_t;

    // Configuration handed to the shift engine
    typedef struct packed {
        logic port_enable;
        logic master_enable;
        logic slave_mode;
    } spcsr_cfg_t;

endpackage

`default_nettype wire

// *** hdl/spcsr_sync.sv ***
`default_nettype none

module spcsr_sync #(
    parameter logic RESET_VAL = 1'h0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out
    input wire logic d,
    output logic q
);

    logic meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// *** hdl/spcsr_flags.sv ***
`default_nettype none

module spcsr_flags #(
    parameter int N = spcsr_pkg::FLAG_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Hardware set and software clear, one bit per flag
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // Set beats clear so an event in the clearing cycle survives
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    q[i] <= 1'h0;
                end else if (set[i]) begin
                    q[i] <= 1'h1;
                end else if (clr[i]) begin
                    q[i] <= 1'h0;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// *** testbench/spcsr_engine_model.sv ***
`default_nettype none

module spcsr_engine_model #(
    parameter int LEN = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench requests
    input wire logic go,
    input wire logic poke,
    input wire logic rx_full,
    // Towards the block
    output spcsr_pkg::spcsr_evt_t evt,
    output logic idle
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_reg;

    // Requests while a transfer runs are dropped, as a real engine would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h00;
        end else if (go && cnt_reg == 8'h00) begin
            cnt_reg <= LEN[7:0];
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // Last bit and done share the final active cycle
    always_comb begin
        evt.xfer_active = cnt_reg != 8'h00;
        evt.last_bit_shifted = cnt_reg == 8'h01;
        evt.xfer_done = cnt_reg == 8'h01;
        evt.data_write = poke;
        evt.rx_buf_full = rx_full;
    end

    assign idle = cnt_reg == 8'h00;
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end

    typedef struct packed {
        logic [3:0] a;
        logic [7:0] wd;
        logic [3:0] be;
        logic [7:0] rd;
        logic [2:0] cf;
    } spcsr_row_t;

    // Writes then readback; pin high throughout
    localparam spcsr_row_t ROWS [8] = '{
        '{4'h0, 8'h01, 4'hF, 8'h01, 3'b101},
        '{4'h0, 8'h03, 4'hF, 8'h03, 3'b110},
        '{4'h0, 8'h0E, 4'hF, 8'h02, 3'b010},
        '{4'h4, 8'hFF, 4'hF, 8'hF0, 3'b010},
        '{4'h8, 8'hFF, 4'hF, 8'h00, 3'b010},
        '{4'h4, 8'h00, 4'hF, 8'h00, 3'b010},
        '{4'h0, 8'h00, 4'hF, 8'h00, 3'b000},
        '{4'h0, 8'h03, 4'h0, 8'h00, 3'b000}
    };

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic slave_select_n = 1'b1;
    logic go = 1'b0;
    logic poke = 1'b0;
    logic rx_full = 1'b0;
    logic idle;
    logic irq;
    spcsr_pkg::spcsr_evt_t evt;
    spcsr_pkg::spcsr_cfg_t cfg;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    spcsr_top dut (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .slave_select_n(slave_select_n), .evt(evt), .cfg(cfg), .irq(irq)
    );

    spcsr_engine_model #(.LEN(12)) eng (
        .clk(clk), .rst(rst), .go(go), .poke(poke), .rx_full(rx_full),
        .evt(evt), .idle(idle)
    );

    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Whole run is a few hundred cycles; a hang is anything far beyond
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // No cap of its own: a request that is never answered runs into the
    // cycle ceiling above, which counts it and ends the run
    task automatic wait_ack;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d,
                          input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    task automatic check_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        `CHK(avs_readdata, {24'h000000, e})
        avs_read <= 1'b0;
    endtask

    task automatic xfer(input logic w);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        poke <= w;
        @(posedge clk);
        poke <= 1'b0;
    endtask

    // Flag lands one cycle after the event, irq one more
    task automatic wait_idle;
        int n;
        for (n = 0; n < 40 && idle !== 1'b1; n++)
            @(posedge clk);
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        check_rd(4'h0, 8'h00);
        check_rd(4'h4, 8'h00);
        `CHK(irq, 1'b0)
        `CHK(cfg, 3'b000)
        for (int i = 0; i < 8; i++) begin
            bus_wr(ROWS[i].a, ROWS[i].wd, ROWS[i].be);
            check_rd(ROWS[i].a, ROWS[i].rd);
            `CHK(cfg, ROWS[i].cf)
        end
        @(posedge clk);
        slave_select_n <= 1'b0;
        repeat (4) @(posedge clk);
        check_rd(4'h0, 8'h04);
        slave_select_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_rd(4'h0, 8'h00);
        bus_wr(4'h0, 8'h03, 4'hF);
        slave_select_n <= 1'b0;
        repeat (5) @(posedge clk);
        check_rd(4'h0, 8'h27);
        `CHK(irq, 1'b0)
        bus_wr(4'h4, 8'hF0, 4'hF);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        slave_select_n <= 1'b1;
        repeat (5) @(posedge clk);
        bus_wr(4'h0, 8'h23, 4'hF);
        check_rd(4'h0, 8'h03);
        `CHK(irq, 1'b0)
        // Collision mid-transfer and overrun at the last bit together
        rx_full <= 1'b1;
        xfer(1'b1);
        check_rd(4'h0, 8'h4B);
        wait_idle();
        check_rd(4'h0, 8'hD3);
        `CHK(irq, 1'b1)
        bus_wr(4'h0, 8'hD3, 4'hF);
        check_rd(4'h0, 8'h03);
        `CHK(irq, 1'b0)
        rx_full <= 1'b0;
        bus_wr(4'h4, 8'h00, 4'hF);
        xfer(1'b0);
        wait_idle();
        check_rd(4'h0, 8'h83);
        `CHK(irq, 1'b0)
        bus_wr(4'h4, 8'h80, 4'hF);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        bus_wr(4'h0, 8'h81, 4'hF);
        xfer(1'b0);
        check_rd(4'h0, 8'h01);
        wait_idle();
        check_rd(4'h0, 8'h81);
        bus_wr(4'h0, 8'h82, 4'hF);
        rx_full <= 1'b1;
        xfer(1'b1);
        wait_idle();
        check_rd(4'h0, 8'h02);
        `CHK(cfg, 3'b010)
        `CHK(irq, 1'b0)
        tally_and_finish();
    end
endmodule

`default_nettype wire
